// ---- rtl/usb_port_cfg_pkg.sv ----
package usb_port_cfg_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] USB_PORT_CONTROL_OFFSET = 8'hE0;
    localparam logic [7:0] TX_SWING_DEEMPHASIS_OFFSET = 8'hE4;
    localparam logic [31:0] USB_PORT_CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] TX_SWING_DEEMPHASIS_RESET = 32'h0000_0000;
    localparam logic [31:0] STICKY_RESET = 32'h0000_0000;

    // ****************************************************************
    // Field layout
    // ****************************************************************
    localparam int NUM_PORTS = 4;
    localparam int SS_FIXED_LSB = 4;
    localparam int HS_FIXED_LSB = 0;
    localparam int FIELD_WIDTH = 4;
    localparam int PORT_FIELD_STRIDE = 8;
    localparam int SWING_LSB = 4;
    localparam int DEEMPH_LSB = 0;
    // Bits of the control word kept in the sticky domain
    localparam logic [31:0] STICKY_MASK = 32'h0000_0000;
    // Bits of the control word that are storage at all
    localparam logic [31:0] CONTROL_RW_MASK = 32'hFFFF_FFFF;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [31:0] wdata;
    } cfg_req_type;

    typedef struct packed {
        logic [3:0] swing;
        logic [3:0] deemph;
    } phy_port_type;

endpackage

// ---- rtl/usb_port_phy_select.sv ----
`timescale 1ns/1ps
module usb_port_phy_select
    import usb_port_cfg_pkg::*;
#(
    parameter int PORTS = NUM_PORTS
) (
    input wire logic [31:0] field_word,
    input wire logic [PORTS-1:0] swing_override,
    input wire logic [PORTS-1:0] deemph_override,
    input wire phy_port_type [PORTS-1:0] default_setting,
    output phy_port_type [PORTS-1:0] applied_setting
);

    // ****************************************************************
    // Per-port override multiplex
    // ****************************************************************
    for (genvar p = 0; p < PORTS; p++) begin : g_port
        localparam int BASE = p * PORT_FIELD_STRIDE;
        always_comb begin
            applied_setting[p] = default_setting[p];
            if (swing_override[p]) begin // [R08]
                applied_setting[p].swing = field_word[BASE+SWING_LSB +: FIELD_WIDTH]; // [R07]
            end
            if (deemph_override[p]) begin // [R08]
                applied_setting[p].deemph = field_word[BASE+DEEMPH_LSB +: FIELD_WIDTH]; // [R07]
            end
        end
    end

endmodule

// ---- rtl/usb_port_config_regs.sv ----
// Notes on behaviour
// [R01] Bits 7:4 force superspeed ports' removable flag
// [R02] Bits 3:0 force high-speed ports' removable flag
// [R03] Two-port variant: ports 3,4 bits inert; the E4h fields of ports 3,4 still drive phy_setting under override
// [R04] Ordinary bits clear on any reset source
// [R05] Sticky bits survive fundamental reset only
// [R06] E4h swing/de-emphasis register, resets to zero
// [R07] E4h values apply only under PHY override
// [R08] Per-port 4-bit swing and de-emphasis fields
// [R09] Fixed-device bits live at E0h, reset zero
// [R10] Config reads return storage; writes act immediately; E4h writes reach phy_setting one cycle after swing_q
`timescale 1ns/1ps
module usb_port_config_regs
    import usb_port_cfg_pkg::*;
#(
    parameter bit FOUR_PORT_VARIANT = 1'b1
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic pcie_fundamental_reset_n,
    input wire logic global_reset_n,
    input wire cfg_req_type cfg_req,
    input wire logic [NUM_PORTS-1:0] swing_override,
    input wire logic [NUM_PORTS-1:0] deemph_override,
    input wire phy_port_type [NUM_PORTS-1:0] default_setting,
    output logic [31:0] cfg_rdata,
    output logic cfg_ack,
    output logic [NUM_PORTS-1:0] ss_device_removable_flag,
    output logic [NUM_PORTS-1:0] hs_device_removable_flag,
    output phy_port_type [NUM_PORTS-1:0] phy_setting
);

    // ****************************************************************
    // Reset pin synchronisers
    // ****************************************************************
    logic [1:0] pcie_fundamental_reset_n_sync_q;
    logic [1:0] pcie_fundamental_reset_n_sync_d;
    logic [1:0] global_reset_n_sync_q;
    logic [1:0] global_reset_n_sync_d;

    always_comb begin
        pcie_fundamental_reset_n_sync_d = {pcie_fundamental_reset_n_sync_q[0], pcie_fundamental_reset_n};
        global_reset_n_sync_d = {global_reset_n_sync_q[0], global_reset_n};
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pcie_fundamental_reset_n_sync_q <= 2'h0;
            global_reset_n_sync_q <= 2'h0;
        end else begin
            pcie_fundamental_reset_n_sync_q <= pcie_fundamental_reset_n_sync_d;
            global_reset_n_sync_q <= global_reset_n_sync_d;
        end
    end

    // Power-on (sys_rst) or global reset clears everything
    logic sticky_clear;
    logic plain_clear;
    assign sticky_clear = sys_rst | ~global_reset_n_sync_q[1]; // [R05]
    assign plain_clear = sticky_clear | ~pcie_fundamental_reset_n_sync_q[1]; // [R04]

    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [31:0] control_q;
    logic [31:0] control_d;
    logic [31:0] swing_q;
    logic [31:0] swing_d;
    logic wr_control;
    logic wr_swing;

    assign wr_control = cfg_req.wr && (cfg_req.addr == USB_PORT_CONTROL_OFFSET); // [R09]
    assign wr_swing = cfg_req.wr && (cfg_req.addr == TX_SWING_DEEMPHASIS_OFFSET); // [R06]

    always_comb begin
        control_d = control_q;
        swing_d = swing_q;
        if (wr_control) begin
            control_d = cfg_req.wdata & CONTROL_RW_MASK; // [R10]
        end
        if (wr_swing) begin
            swing_d = cfg_req.wdata; // [R10]
        end
    end

    // Sticky bits held apart so a fundamental reset leaves them alone
    always_ff @(posedge clk_sys) begin
        if (plain_clear) begin
            control_q <= (USB_PORT_CONTROL_RESET & ~STICKY_MASK) | (control_q & STICKY_MASK); // [R04]
            swing_q <= TX_SWING_DEEMPHASIS_RESET; // [R06]
            if (sticky_clear) begin
                control_q <= USB_PORT_CONTROL_RESET; // [R05]
            end
        end else begin
            control_q <= control_d;
            swing_q <= swing_d;
        end
    end

    // ****************************************************************
    // Read path and forced flags
    // ****************************************************************
    function automatic logic [31:0] read_mux(input logic [7:0] addr, input logic [31:0] c, input logic [31:0] s);
        case (addr)
            USB_PORT_CONTROL_OFFSET: read_mux = c;
            TX_SWING_DEEMPHASIS_OFFSET: read_mux = s;
            default: read_mux = 32'h0000_0000;
        endcase
    endfunction

    logic [31:0] rdata_d;
    logic ack_d;
    logic [NUM_PORTS-1:0] port_present;
    logic [NUM_PORTS-1:0] ss_flag_d;
    logic [NUM_PORTS-1:0] hs_flag_d;
    phy_port_type [NUM_PORTS-1:0] applied;

    // Ports 3 and 4 are absent on the two-port part
    assign port_present = FOUR_PORT_VARIANT ? 4'hF : 4'h3; // [R03]

    always_comb begin
        rdata_d = cfg_req.rd ? read_mux(cfg_req.addr, control_q, swing_q) : cfg_rdata; // [R10]
        ack_d = cfg_req.rd | cfg_req.wr;
        // Driven from control_d so the flag follows the write on the same edge
        ss_flag_d = control_d[SS_FIXED_LSB +: NUM_PORTS] & port_present; // [R01]
        hs_flag_d = control_d[HS_FIXED_LSB +: NUM_PORTS] & port_present; // [R02]
    end

    usb_port_phy_select #(
        .PORTS(NUM_PORTS)
    ) u_phy_select (
        .field_word(swing_q),
        .swing_override(swing_override),
        .deemph_override(deemph_override),
        .default_setting(default_setting),
        .applied_setting(applied)
    );

    always_ff @(posedge clk_sys) begin
        if (plain_clear) begin
            cfg_rdata <= 32'h0000_0000;
            cfg_ack <= 1'b0;
            ss_device_removable_flag <= 4'h0;
            hs_device_removable_flag <= 4'h0;
            phy_setting <= default_setting;
        end else begin
            cfg_rdata <= rdata_d;
            cfg_ack <= ack_d;
            ss_device_removable_flag <= ss_flag_d; // [R01]
            hs_device_removable_flag <= hs_flag_d; // [R02]
            phy_setting <= applied; // [R07]
        end
    end

endmodule

// ---- verification/usb_port_cfg_assertions.sv ----
`timescale 1ns/1ps
module usb_port_cfg_assertions
    import usb_port_cfg_pkg::*;
#(
    parameter bit FOUR_PORT_VARIANT = 1'b1
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic pcie_fundamental_reset_n,
    input wire logic global_reset_n,
    input wire cfg_req_type cfg_req,
    input wire logic [NUM_PORTS-1:0] swing_override,
    input wire logic [NUM_PORTS-1:0] deemph_override,
    input wire phy_port_type [NUM_PORTS-1:0] default_setting,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_ack,
    input wire logic [NUM_PORTS-1:0] ss_device_removable_flag,
    input wire logic [NUM_PORTS-1:0] hs_device_removable_flag,
    input wire phy_port_type [NUM_PORTS-1:0] phy_setting
);
    // ****************************************************************
    // Config-access and port-side checks
    // ****************************************************************
    // Absent ports on the two-port part must never report a fixed device
    wire [3:0] live_mask = FOUR_PORT_VARIANT ? 4'hF : 4'h3;
    wire wr_e0 = cfg_req.wr && cfg_req.addr == USB_PORT_CONTROL_OFFSET;
    default clocking @(posedge clk_sys); endclocking
    // Pin resets act through a synchroniser, so checks rest while any is low
    default disable iff (sys_rst || !pcie_fundamental_reset_n || !global_reset_n);
    a_ack_after_req: assert property ((cfg_req.rd || cfg_req.wr) |=> cfg_ack)
        else $error("request without ack");
    a_ss_flag_write: assert property (wr_e0 |=> ss_device_removable_flag == ($past(cfg_req.wdata[7:4]) & live_mask))
        else $error("superspeed flag mismatch");
    a_hs_flag_write: assert property (wr_e0 |=> hs_device_removable_flag == ($past(cfg_req.wdata[3:0]) & live_mask))
        else $error("high-speed flag mismatch");
    a_flags_hold: assert property (!cfg_req.wr |=> $stable(ss_device_removable_flag) && $stable(hs_device_removable_flag))
        else $error("flags moved without write");
    a_rdata_hold: assert property (!cfg_req.rd |=> $stable(cfg_rdata))
        else $error("read data moved without read");
    a_unmapped_zero: assert property (cfg_req.rd && cfg_req.addr != USB_PORT_CONTROL_OFFSET
        && cfg_req.addr != TX_SWING_DEEMPHASIS_OFFSET |=> cfg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_phy_default: assert property ((swing_override == 4'h0 && deemph_override == 4'h0) [*2] ##0 $stable(default_setting)
        |-> phy_setting == default_setting)
        else $error("phy setting overridden without enable");
    a_reset_clear: assert property (disable iff (1'b0) sys_rst |=> ss_device_removable_flag == 4'h0
        && hs_device_removable_flag == 4'h0 && cfg_rdata == 32'h0)
        else $error("reset did not clear");
endmodule
bind usb_port_config_regs usb_port_cfg_assertions #(.FOUR_PORT_VARIANT(FOUR_PORT_VARIANT)) u_chk (.clk_sys, .sys_rst,
    .pcie_fundamental_reset_n, .global_reset_n, .cfg_req, .swing_override, .deemph_override, .default_setting,
    .cfg_rdata, .cfg_ack, .ss_device_removable_flag, .hs_device_removable_flag, .phy_setting);

// ---- verification/test_usb_port_config_regs.sv ----
`timescale 1ns/1ps
module test_usb_port_config_regs;
    import usb_port_cfg_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic pcie_fundamental_reset_n = 1'b1;
    logic global_reset_n = 1'b1;
    cfg_req_type cfg_req = '0;
    logic [3:0] swing_override = 4'h0;
    logic [3:0] deemph_override = 4'h0;
    phy_port_type [3:0] default_setting = 32'hA5C3_5A3C;
    logic [31:0] cfg_rdata, rdata2, got, sel;
    logic cfg_ack;
    logic [3:0] ss_device_removable_flag, hs_device_removable_flag, ss2, hs2;
    phy_port_type [3:0] phy_setting;
    logic [31:0] e4_word = 32'h1234_5678;
    int n_fail = 0;
    int n_tests = 0;
    always #10 clk_sys = ~clk_sys;
    usb_port_config_regs DUT (.clk_sys, .sys_rst, .pcie_fundamental_reset_n, .global_reset_n, .cfg_req,
        .swing_override, .deemph_override, .default_setting, .cfg_rdata, .cfg_ack, .ss_device_removable_flag,
        .hs_device_removable_flag, .phy_setting);
    usb_port_config_regs #(.FOUR_PORT_VARIANT(1'b0)) two_port (.clk_sys, .sys_rst, .pcie_fundamental_reset_n,
        .global_reset_n, .cfg_req, .swing_override, .deemph_override, .default_setting, .cfg_rdata(rdata2),
        .cfg_ack(), .ss_device_removable_flag(ss2), .hs_device_removable_flag(hs2), .phy_setting());
    // ****************************************************************
    // Access and compare tasks
    // ****************************************************************
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Request is a one-cycle pulse; ack and data are valid in the following cycle
    task acc(input logic rd, input logic [7:0] addr, input logic [31:0] wdata);
        @(negedge clk_sys);
        cfg_req = '{rd: rd, wr: !rd, addr: addr, wdata: wdata};
        @(negedge clk_sys);
        cfg_req = '0;
        got = cfg_rdata;
        chk("ack", {31'h0, cfg_ack}, 32'h1);
    endtask
    task finish_test;
        if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (3) @(negedge clk_sys);
        acc(1'b1, USB_PORT_CONTROL_OFFSET, 32'h0);
        chk("e0 reset", got, USB_PORT_CONTROL_RESET);
        acc(1'b1, TX_SWING_DEEMPHASIS_OFFSET, 32'h0);
        chk("e4 reset", got, TX_SWING_DEEMPHASIS_RESET);
        for (int i = 0; i < 8; i++) begin
            acc(1'b0, USB_PORT_CONTROL_OFFSET, 32'h1 << i);
            chk("ss flag", {28'h0, ss_device_removable_flag}, (32'h1 << i) >> 4);
            chk("hs flag", {28'h0, hs_device_removable_flag}, (32'h1 << i) & 32'hF);
            chk("two port flags", {24'h0, ss2, hs2}, (32'h1 << i) & 32'h33);
        end
        acc(1'b0, USB_PORT_CONTROL_OFFSET, 32'hFFFF_FFFF);
        acc(1'b1, USB_PORT_CONTROL_OFFSET, 32'h0);
        chk("e0 read", got, 32'hFFFF_FFFF);
        chk("two port read", rdata2, 32'hFFFF_FFFF);
        acc(1'b1, 8'hE8, 32'h0);
        chk("unmapped", got, 32'h0);
        acc(1'b0, TX_SWING_DEEMPHASIS_OFFSET, e4_word);
        acc(1'b1, TX_SWING_DEEMPHASIS_OFFSET, 32'h0);
        chk("e4 read", got, e4_word);
        for (int m = 0; m < 4; m++) begin
            swing_override = {4{m[0]}};
            deemph_override = {4{m[1]}};
            sel = (m[0] ? 32'hF0F0_F0F0 : 32'h0) | (m[1] ? 32'h0F0F_0F0F : 32'h0);
            repeat (2) @(negedge clk_sys);
            chk("phy", phy_setting, (e4_word & sel) | (default_setting & ~sel));
        end
        for (int p = 0; p < 2; p++) begin
            acc(1'b0, USB_PORT_CONTROL_OFFSET, 32'hFFFF_FFFF);
            if (p == 0) pcie_fundamental_reset_n = 1'b0;
            else global_reset_n = 1'b0;
            repeat (4) @(negedge clk_sys);
            pcie_fundamental_reset_n = 1'b1;
            global_reset_n = 1'b1;
            repeat (4) @(negedge clk_sys);
            chk("flags cleared", {24'h0, ss_device_removable_flag, hs_device_removable_flag}, 32'h0);
            acc(1'b1, USB_PORT_CONTROL_OFFSET, 32'h0);
            chk("e0 after reset", got, p == 0 ? STICKY_MASK : STICKY_RESET);
            acc(1'b1, TX_SWING_DEEMPHASIS_OFFSET, 32'h0);
            chk("e4 after reset", got, TX_SWING_DEEMPHASIS_RESET);
        end
        finish_test();
    end
endmodule
